// ### core/epsa_pkg.sv
/*
 * Shared constants for the second-enable-pin supply assignment block.
 * Assumes an 8-bit register port and 8-bit voltage selection codes.
 */
package epsa_pkg;
    localparam logic [7:0] ASSIGN_OFFSET = 8'h48;
    localparam logic [7:0] ASSIGN_RESET = 8'h00;
    localparam logic [7:0] ASSIGN_RW_MASK = 8'h1F;
    localparam int IO_RAIL_BIT = 0;
    localparam int CORE_A_BIT = 1;
    localparam int CORE_B_BIT = 2;
    localparam int EXT_CONV_BIT = 3;
    localparam int SPARE_BIT = 4;
    localparam logic [7:0] VSEL_OFF = 8'h00;
    localparam int NUM_SMPS = 3;

    typedef enum logic [2:0] {
        EPSA_OFF = 3'b001,
        EPSA_ON = 3'b010,
        EPSA_LOWPOWER = 3'b100
    } epsa_mode_t;
endpackage

// ### core/epsa_sel.sv
/*
 * Per-converter selection: mode, and voltage unless i_fixed_on, from the pin when assigned.
 * Assumes all inputs are synchronous to i_clk_sys; outputs are registered.
 */
`timescale 1ns/1ps
`default_nettype none
module epsa_sel
    import epsa_pkg::*;
(
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rstn,
    // Control
    input wire logic i_assign,
    input wire logic i_pin,
    input wire logic i_keep_on,
    input wire logic i_fixed_on,
    // Voltage settings
    input wire logic [7:0] i_op_vsel,
    input wire logic [7:0] i_sr_vsel,
    input wire logic [7:0] i_reg_vsel,
    input wire logic [2:0] i_reg_mode,
    // Result
    output logic [7:0] o_vsel,
    output logic [2:0] o_mode
);
    logic [7:0] next_vsel;
    epsa_mode_t next_mode;

    always_comb begin
        next_vsel = i_reg_vsel;
        next_mode = epsa_mode_t'(i_reg_mode);
        if (i_assign) begin
            if (i_fixed_on) begin
                // The I/O rail has no sleep register, only on, off or low power.
                next_vsel = i_reg_vsel;
                next_mode = i_pin ? EPSA_ON : (i_keep_on ? EPSA_LOWPOWER : EPSA_OFF);
            end else begin
                next_vsel = i_pin ? i_op_vsel : i_sr_vsel;
                if (next_vsel == VSEL_OFF) begin
                    next_mode = EPSA_OFF;
                end else if (!i_pin && i_keep_on) begin
                    next_mode = EPSA_LOWPOWER;
                end else begin
                    next_mode = EPSA_ON;
                end
            end
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_rstn) begin
            o_vsel <= VSEL_OFF;
            o_mode <= EPSA_OFF;
        end else begin
            o_vsel <= next_vsel;
            o_mode <= next_mode;
        end
    end
endmodule
`default_nettype wire

// ### core/epsa_top.sv
/*
 * Second enable pin supply assignment register and converter control muxing.
 * Assumes a simple synchronous 8-bit register port and a pin already synchronous.
 */
`timescale 1ns/1ps
`default_nettype none
module epsa_top
    import epsa_pkg::*;
(
    // Clock and turn-off reset
    input wire logic i_clk_sys,
    input wire logic i_rstn,
    // Register port
    input wire logic [7:0] i_reg_addr,
    input wire logic i_reg_wr,
    input wire logic [7:0] i_reg_wdata,
    output logic [7:0] o_reg_rdata,
    // Second enable pin, driven by the host
    input wire logic i_second_enable_pin,
    // Keep-on settings
    input wire logic [3:0] i_sleep_keep_on_bits,
    // Voltage registers
    input wire logic [7:0] i_core_a_operating_voltage,
    input wire logic [7:0] i_core_a_sleep_voltage,
    input wire logic [7:0] i_core_b_operating_voltage,
    input wire logic [7:0] i_core_b_sleep_voltage,
    input wire logic [7:0] i_ext_converter_operating_voltage,
    input wire logic [7:0] i_ext_converter_sleep_voltage,
    // Register-programmed state used when not assigned
    input wire logic [31:0] i_reg_vsel,
    input wire logic [11:0] i_reg_mode,
    // Resulting supply control
    output logic [31:0] o_vsel,
    output logic [11:0] o_mode
);
    logic [7:0] pin_supply_assign;
    logic [31:0] op_v;
    logic [31:0] sr_v;

    // One decode serves the write and the read path, so they can never disagree on the map.
    function automatic logic is_assign_addr(input logic [7:0] addr);
        return addr == ASSIGN_OFFSET;
    endfunction

    // Only bits 4:0 hold state, so reserved bits always read zero.
    always_ff @(posedge i_clk_sys) begin
        if (!i_rstn) begin
            pin_supply_assign <= ASSIGN_RESET;
        end else if (i_reg_wr && is_assign_addr(i_reg_addr)) begin
            pin_supply_assign <= i_reg_wdata & ASSIGN_RW_MASK;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_rstn) begin
            o_reg_rdata <= 8'h00;
        end else if (is_assign_addr(i_reg_addr)) begin
            o_reg_rdata <= pin_supply_assign & ASSIGN_RW_MASK;
        end else begin
            o_reg_rdata <= 8'h00;
        end
    end

    // The I/O rail has no operating or sleep voltage register, so its slot is tied off.
    assign op_v = {i_ext_converter_operating_voltage, i_core_b_operating_voltage,
                   i_core_a_operating_voltage, VSEL_OFF};
    assign sr_v = {i_ext_converter_sleep_voltage, i_core_b_sleep_voltage,
                   i_core_a_sleep_voltage, VSEL_OFF};

    // Index 0 io rail, 1 core A, 2 core B, 3 external converter.
    for (genvar g = 0; g <= NUM_SMPS; g++) begin : g_sel
        epsa_sel u_sel (
            .i_clk_sys(i_clk_sys),
            .i_rstn(i_rstn),
            .i_assign(pin_supply_assign[g]),
            .i_pin(i_second_enable_pin),
            .i_keep_on(i_sleep_keep_on_bits[g]),
            .i_fixed_on(g == IO_RAIL_BIT),
            .i_op_vsel(op_v[g*8 +: 8]),
            .i_sr_vsel(sr_v[g*8 +: 8]),
            .i_reg_vsel(i_reg_vsel[g*8 +: 8]),
            .i_reg_mode(i_reg_mode[g*3 +: 3]),
            .o_vsel(o_vsel[g*8 +: 8]),
            .o_mode(o_mode[g*3 +: 3])
        );
    end

    // Outputs and read data are registered, so each implication check looks one edge after its cause.
    rsv_zero_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        o_reg_rdata[7:5] == 3'b000)
        else $error("reserved bits not zero");
    rsv_store_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        pin_supply_assign[7:5] == 3'b000)
        else $error("reserved bits hold state");
    read_back_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        is_assign_addr(i_reg_addr)
        |=> o_reg_rdata == $past(pin_supply_assign))
        else $error("read data differs from stored assignment");
    spare_store_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        i_reg_wr && is_assign_addr(i_reg_addr)
        |=> pin_supply_assign[SPARE_BIT] == $past(i_reg_wdata[SPARE_BIT]))
        else $error("spare bit not stored");
    reset_clr_a: assert property (@(posedge i_clk_sys)
        !i_rstn
        |=> pin_supply_assign == ASSIGN_RESET)
        else $error("assign not cleared");

    // Without its assignment bit a converter passes its register programming through.
    unassigned_io_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        !pin_supply_assign[IO_RAIL_BIT]
        |=> o_vsel[7:0] == $past(i_reg_vsel[7:0])
        && o_mode[2:0] == $past(i_reg_mode[2:0]))
        else $error("unassigned io rail followed pin");
    unassigned_pass_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        !pin_supply_assign[CORE_A_BIT]
        |=> o_vsel[15:8] == $past(i_reg_vsel[15:8])
        && o_mode[5:3] == $past(i_reg_mode[5:3]))
        else $error("unassigned core A followed pin");
    unassigned_b_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        !pin_supply_assign[CORE_B_BIT]
        |=> o_vsel[23:16] == $past(i_reg_vsel[23:16])
        && o_mode[8:6] == $past(i_reg_mode[8:6]))
        else $error("unassigned core B followed pin");
    unassigned_ext_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        !pin_supply_assign[EXT_CONV_BIT]
        |=> o_vsel[31:24] == $past(i_reg_vsel[31:24])
        && o_mode[11:9] == $past(i_reg_mode[11:9]))
        else $error("unassigned external followed pin");

    core_a_op_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        pin_supply_assign[CORE_A_BIT] && i_second_enable_pin
        |=> o_vsel[15:8] == $past(i_core_a_operating_voltage))
        else $error("core A op voltage wrong");
    core_a_sr_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        pin_supply_assign[CORE_A_BIT] && !i_second_enable_pin
        |=> o_vsel[15:8] == $past(i_core_a_sleep_voltage))
        else $error("core A sleep voltage wrong");
    core_a_on_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        pin_supply_assign[CORE_A_BIT] && i_second_enable_pin
        && i_core_a_operating_voltage != VSEL_OFF
        |=> o_mode[5:3] == EPSA_ON)
        else $error("core A not on");
    core_a_lp_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        pin_supply_assign[CORE_A_BIT] && !i_second_enable_pin
        && i_sleep_keep_on_bits[CORE_A_BIT] && i_core_a_sleep_voltage != VSEL_OFF
        |=> o_mode[5:3] == EPSA_LOWPOWER)
        else $error("core A not low power");
    core_a_off_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        pin_supply_assign[CORE_A_BIT] && (i_second_enable_pin
        ? i_core_a_operating_voltage : i_core_a_sleep_voltage) == VSEL_OFF
        |=> o_mode[5:3] == EPSA_OFF)
        else $error("core A not off");

    core_b_sel_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        pin_supply_assign[CORE_B_BIT]
        |=> o_vsel[23:16] == ($past(i_second_enable_pin)
        ? $past(i_core_b_operating_voltage) : $past(i_core_b_sleep_voltage)))
        else $error("core B selection wrong");
    core_b_on_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        pin_supply_assign[CORE_B_BIT] && i_second_enable_pin
        && i_core_b_operating_voltage != VSEL_OFF
        |=> o_mode[8:6] == EPSA_ON)
        else $error("core B not on");
    core_b_lp_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        pin_supply_assign[CORE_B_BIT] && !i_second_enable_pin
        && i_sleep_keep_on_bits[CORE_B_BIT] && i_core_b_sleep_voltage != VSEL_OFF
        |=> o_mode[8:6] == EPSA_LOWPOWER)
        else $error("core B not low power");
    core_b_off_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        pin_supply_assign[CORE_B_BIT] && (i_second_enable_pin
        ? i_core_b_operating_voltage : i_core_b_sleep_voltage) == VSEL_OFF
        |=> o_mode[8:6] == EPSA_OFF)
        else $error("core B not off");

    ext_sel_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        pin_supply_assign[EXT_CONV_BIT] && i_second_enable_pin
        |=> o_vsel[31:24] == $past(i_ext_converter_operating_voltage))
        else $error("external op wrong");
    ext_sr_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        pin_supply_assign[EXT_CONV_BIT] && !i_second_enable_pin
        |=> o_vsel[31:24] == $past(i_ext_converter_sleep_voltage))
        else $error("external sleep wrong");
    ext_on_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        pin_supply_assign[EXT_CONV_BIT] && i_second_enable_pin
        && i_ext_converter_operating_voltage != VSEL_OFF
        |=> o_mode[11:9] == EPSA_ON)
        else $error("external not on");
    ext_lp_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        pin_supply_assign[EXT_CONV_BIT] && !i_second_enable_pin
        && i_sleep_keep_on_bits[EXT_CONV_BIT] && i_ext_converter_sleep_voltage != VSEL_OFF
        |=> o_mode[11:9] == EPSA_LOWPOWER)
        else $error("external not low power");
    ext_off_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        pin_supply_assign[EXT_CONV_BIT] && (i_second_enable_pin
        ? i_ext_converter_operating_voltage : i_ext_converter_sleep_voltage) == VSEL_OFF
        |=> o_mode[11:9] == EPSA_OFF)
        else $error("external not off");

    io_rail_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        pin_supply_assign[IO_RAIL_BIT]
        |=> o_mode[2:0] == ($past(i_second_enable_pin)
        ? EPSA_ON : ($past(i_sleep_keep_on_bits[IO_RAIL_BIT]) ? EPSA_LOWPOWER : EPSA_OFF)))
        else $error("io rail mode wrong");

    cov_core_a_lp: cover property (@(posedge i_clk_sys) o_mode[5:3] == EPSA_LOWPOWER);
    cov_io_off: cover property (@(posedge i_clk_sys)
        pin_supply_assign[IO_RAIL_BIT] ##1 o_mode[2:0] == EPSA_OFF);
    cov_pin_fall: cover property (@(posedge i_clk_sys)
        pin_supply_assign[CORE_B_BIT] && $fell(i_second_enable_pin));
    cov_ext_lp: cover property (@(posedge i_clk_sys)
        pin_supply_assign[EXT_CONV_BIT] ##1 o_mode[11:9] == EPSA_LOWPOWER);
    cov_spare_write: cover property (@(posedge i_clk_sys)
        i_reg_wr && is_assign_addr(i_reg_addr) && i_reg_wdata[SPARE_BIT]);
endmodule
`default_nettype wire

// ### verification/epsa_host_model.sv
/*
 * Host model that drives the second enable pin.
 * Assumes the bench supplies the requested level on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none
module epsa_host_model (
    // Clock
    input wire logic i_clk_sys,
    // Request and pin
    input wire logic i_req_operating,
    output logic o_pin
);
    // The host moves the pin on its clock edge, so the pin never changes mid-cycle.
    always_ff @(posedge i_clk_sys) begin
        o_pin <= i_req_operating;
    end
endmodule
`default_nettype wire

// ### verification/tb_top.sv
/*
 * Self-checking bench for the supply assignment block.
 * Assumes the host model drives the pin and the bench drives everything else.
 */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import epsa_pkg::*;
    logic i_clk_sys = 1'b0;
    logic i_rstn = 1'b0;
    logic [7:0] i_reg_addr = 8'h48;
    logic i_reg_wr = 1'b0;
    logic [7:0] i_reg_wdata = 8'h00;
    logic [7:0] o_reg_rdata;
    logic req = 1'b1;
    logic pin;
    logic [3:0] keep = 4'h0;
    logic [7:0] v [6];
    logic [31:0] reg_v = 32'h4433_2211;
    logic [11:0] reg_m = 12'h88A;
    logic [7:0] wv [4] = '{8'h10, 8'hFF, 8'h05, 8'h0A};
    logic [43:0] exp_out;
    logic [31:0] o_vsel;
    logic [11:0] o_mode;
    int mismatches = 0;
    int samples_checked = 0;
    int cycles = 0;
    always #12.5 i_clk_sys = ~i_clk_sys;
    epsa_host_model host (.i_clk_sys(i_clk_sys), .i_req_operating(req), .o_pin(pin));
    epsa_top uut (.i_clk_sys(i_clk_sys), .i_rstn(i_rstn), .i_reg_addr(i_reg_addr),
        .i_reg_wr(i_reg_wr), .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata),
        .i_second_enable_pin(pin), .i_sleep_keep_on_bits(keep),
        .i_core_a_operating_voltage(v[0]), .i_core_a_sleep_voltage(v[1]),
        .i_core_b_operating_voltage(v[2]), .i_core_b_sleep_voltage(v[3]),
        .i_ext_converter_operating_voltage(v[4]), .i_ext_converter_sleep_voltage(v[5]),
        .i_reg_vsel(reg_v), .i_reg_mode(reg_m), .o_vsel(o_vsel), .o_mode(o_mode));
    task automatic complete_run();
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // A hang would otherwise run forever; the whole sequence needs well under 1000 cycles.
    always @(posedge i_clk_sys) begin
        cycles++;
        if (cycles == 3000) begin
            mismatches++;
            complete_run();
        end
    end
    task automatic check(input logic [43:0] got, input logic [43:0] exp);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] d);
        i_reg_wr = 1'b1;
        i_reg_wdata = d;
        @(posedge i_clk_sys) #1;
        i_reg_wr = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        i_reg_addr = a;
        @(posedge i_clk_sys) #1;
        check({36'h0, o_reg_rdata}, {36'h0, exp});
        i_reg_addr = 8'h48;
    endtask
    function automatic logic [43:0] model(logic [3:0] a, logic p, logic [3:0] k, logic off);
        logic [31:0] ev;
        logic [11:0] em;
        logic [7:0] s;
        ev = reg_v;
        em = reg_m;
        if (a[0]) em[2:0] = p ? 3'b010 : (k[0] ? 3'b100 : 3'b001);
        for (int i = 1; i < 4; i++) begin
            s = off ? 8'h00 : (p ? 8'h30 : 8'h10) + 8'(i);
            if (a[i]) begin
                ev[i*8 +: 8] = s;
                em[i*3 +: 3] = (s == 8'h00) ? 3'b001 : ((!p && k[i]) ? 3'b100 : 3'b010);
            end
        end
        return {ev, em};
    endfunction
    initial begin
        for (int i = 0; i < 6; i++) v[i] = 8'h00;
        repeat (16) @(posedge i_clk_sys);
        #1 i_rstn = 1'b1;
        rd(8'h48, 8'h00);
        foreach (wv[w]) begin
            wr(wv[w]);
            rd(8'h48, wv[w] & 8'h1F);
            rd(8'h47, 8'h00);
            for (int c = 0; c < 8; c++) begin
                req = c[0];
                keep = c[1] ? 4'hF : 4'h0;
                for (int i = 0; i < 6; i++) v[i] = c[2] ? 8'h00 : 8'h31 + 8'(i / 2) - 8'(i % 2 * 32);
                repeat (3) @(posedge i_clk_sys);
                #1 exp_out = model(wv[w][3:0], c[0], keep, c[2]);
                check({o_vsel, o_mode}, exp_out);
            end
        end
        i_rstn = 1'b0;
        repeat (2) @(posedge i_clk_sys);
        #1 check({o_vsel, o_mode}, {{4{VSEL_OFF}}, {4{EPSA_OFF}}});
        i_rstn = 1'b1;
        rd(8'h48, 8'h00);
        repeat (2) @(posedge i_clk_sys);
        #1 check({o_vsel, o_mode}, {reg_v, reg_m});
        complete_run();
    end
endmodule
`default_nettype wire
